// >>> design/scci_top.sv
/*
  serial configuration command interpreter with apb register slave.
  assumes the uart delivers received bytes as one-cycle pulses and
  accepts a byte on tx_valid and tx_ready; all inputs are synchronous.
*/
// What this block does
// - a command is start-of-text, ascii digits, then end-of-text.
// - digits are bytes 30h to 39h, decoded back to numerals.
// - a framed, recognised command in programming mode answers one ack byte.
// - a bad command in programming mode, including a non-digit like colon, answers one nak byte.
// - after a nak the session is dropped; host restarts with entry command.
// - in programming mode motor, laser and decoding are held off.
// - a 20 s gap between commands in programming mode gives nak and exit.
// - six nines outside programming mode enters it with an ack.
// - six nines inside programming mode leaves it with ack and three beeps.
// - current line settings serve programming; reset gives 9600, space, 2, 7.
// - line setting changes are held pending until six nines leave programming mode; a nak or gap timeout drops them.
// - five nines and an eight in programming mode restore factory defaults and ack.
// - each parameter digit comes as its own frame and is acked.
`timescale 1ns/1ns
module scci_top #(
  parameter longint unsigned GAP_CYCLES = scci_pkg::GAP_CYCLES
) (
  input  wire logic                     SYS_CLK,
  input  wire logic                     RST,
  input  wire logic                     PSEL,
  input  wire logic                     PENABLE,
  input  wire logic                     PWRITE,
  input  wire logic [scci_pkg::APB_AW-1:0] PADDR,
  input  wire logic [31:0]              PWDATA,
  output logic      [31:0]              PRDATA,
  output logic                          PREADY,
  output logic                          PSLVERR,
  input  wire logic                     RX_VALID,
  input  wire logic [7:0]               RX_DATA,
  output logic                          TX_VALID,
  output logic      [7:0]               TX_DATA,
  input  wire logic                     TX_READY,
  output logic                          PROG_MODE,
  output logic                          MOTOR_EN,
  output logic                          LASER_EN,
  output logic                          DECODE_EN,
  output logic                          BEEP_STB,
  output logic      [1:0]               BEEP_COUNT,
  output logic                          DEFAULTS_STB,
  output logic                          CMD_VALID,
  output logic                          CMD_LINE,
  output scci_pkg::scci_cmd_t           CMD_DATA,
  output scci_pkg::scci_line_t          LINE_CFG,
  output logic                          IRQ
);
  import scci_pkg::*;

  localparam int GAP_W = $clog2(GAP_CYCLES + 1);

  // ==========================================================================
  // parameter check
  generate
    if (GAP_CYCLES < 2) begin : g_bad_gap
      $error("gap count too small");
    end
  endgenerate

  // ==========================================================================
  // state
  scci_mode_t       mode_reg;
  scci_mode_t       mode_next;
  logic [GAP_W-1:0] gap_cnt_reg;
  logic [GAP_W-1:0] gap_cnt_next;
  scci_line_t       pend_reg;
  scci_line_t       pend_next;
  scci_line_t       act_reg;
  scci_cmd_t        last_cmd_reg;
  logic             ctrl_en_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_stat_next;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [IRQ_W-1:0] irq_mask_next;
  logic [31:0]      prdata_reg;
  logic             pready_reg;
  logic             pslverr_reg;
  logic             tx_valid_reg;
  logic [7:0]       tx_data_reg;
  logic             prog_reg;
  logic             scan_en_reg;
  logic             beep_stb_reg;
  logic [1:0]       beep_cnt_reg;
  logic             dflt_stb_reg;
  logic             cmd_valid_reg;
  logic             cmd_line_reg;
  scci_cmd_t        cmd_data_reg;
  logic             irq_reg;
  scci_cmd_t        fr_cmd;
  logic             fr_done;
  logic             fr_bad;

  // ==========================================================================
  // framer
  scci_framer u_framer (
    .clk      (SYS_CLK),
    .rst      (RST),
    .rx_valid (RX_VALID),
    .rx_data  (RX_DATA),
    .cmd      (fr_cmd),
    .done     (fr_done),
    .bad      (fr_bad)
  );

  // ==========================================================================
  // command decode
  wire in_prog  = (mode_reg == MODE_PROG);
  wire fd       = fr_done && ctrl_en_reg;
  wire good     = !fr_bad && (fr_cmd.count != 3'h0);
  wire full     = good && (fr_cmd.count == FULL_COUNT);
  wire is_prog  = full && (fr_cmd.digits == CODE_PROG);
  wire is_dflt  = full && (fr_cmd.digits == CODE_DEFAULTS);
  wire gap_hit  = in_prog && !fd && (gap_cnt_reg == GAP_W'(GAP_CYCLES - 1));
  wire ev_enter = !in_prog && fd && is_prog;
  wire ev_exit  = in_prog && fd && is_prog;
  wire ev_bad   = in_prog && fd && !good;
  wire ev_abort = ev_bad || gap_hit;
  wire ev_dflt  = in_prog && fd && is_dflt;
  wire ev_cmd   = in_prog && fd && good && !is_prog && !is_dflt;
  wire ev_line  = ev_cmd && (fr_cmd.lead == LINE_CMD_LEAD);
  wire tx_load  = ev_enter || (in_prog && fd) || gap_hit;
  wire [7:0] tx_code = ev_abort ? CH_NAK : CH_ACK;

  assign mode_next = (ev_enter) ? MODE_PROG :
                     (ev_exit || ev_abort) ? MODE_RUN : mode_reg;

  // gap restarts at each command; only counts in programming mode
  assign gap_cnt_next = (!in_prog || fd || gap_hit) ? '0 : gap_cnt_reg + GAP_W'(1);

  // ==========================================================================
  // apb decode
  wire setup   = PSEL && !PENABLE;
  wire access  = PSEL && PENABLE && pready_reg;
  wire sel_ctrl = (PADDR == ADDR_CTRL);
  wire sel_stat = (PADDR == ADDR_STAT);
  wire sel_irqs = (PADDR == ADDR_IRQS);
  wire sel_irqm = (PADDR == ADDR_IRQM);
  wire sel_pend = (PADDR == ADDR_PEND);
  wire sel_act  = (PADDR == ADDR_ACT);
  wire sel_last = (PADDR == ADDR_LAST);
  wire hit      = sel_ctrl || sel_stat || sel_irqs || sel_irqm || sel_pend || sel_act
                  || sel_last;
  wire wr       = access && PWRITE && !pslverr_reg;
  wire pend_differs = (pend_reg != act_reg);

  wire [31:0] rd_status = (32'(in_prog) << ST_PROG_BIT) | (32'(pend_differs) << ST_PEND_BIT)
                          | (32'(tx_valid_reg) << ST_TXBUSY_BIT);
  wire [31:0] rd_data = sel_ctrl ? (32'(ctrl_en_reg) << CTRL_EN_BIT) :
                        sel_stat ? rd_status :
                        sel_irqs ? 32'(irq_stat_reg) :
                        sel_irqm ? 32'(irq_mask_reg) :
                        sel_pend ? 32'(pend_reg) :
                        sel_act  ? 32'(act_reg) :
                        sel_last ? 32'(last_cmd_reg) : 32'h00000000;

  // hardware events win over a software write to the pending settings
  assign pend_next = (ev_dflt) ? LINE_DEFAULT :
                     (ev_abort) ? act_reg :
                     (wr && sel_pend) ? scci_line_t'(PWDATA[$bits(scci_line_t)-1:0]) :
                     pend_reg;

  wire [IRQ_W-1:0] irq_set = (IRQ_W'(ev_enter) << IRQ_ENTER) | (IRQ_W'(ev_exit) << IRQ_EXIT)
                           | (IRQ_W'(ev_bad) << IRQ_NAK) | (IRQ_W'(gap_hit) << IRQ_TIMEOUT)
                           | (IRQ_W'(ev_dflt) << IRQ_DEFAULT) | (IRQ_W'(ev_line) << IRQ_LINECMD);
  wire [IRQ_W-1:0] irq_clr = (wr && sel_irqs) ? PWDATA[IRQ_W-1:0] : '0;
  // set wins over a write-one clear in the same cycle
  assign irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_set;
  assign irq_mask_next = (wr && sel_irqm) ? PWDATA[IRQ_W-1:0] : irq_mask_reg;

  // ==========================================================================
  // apb slave: one cycle setup, access answered at once
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
    end else begin
      pready_reg  <= setup;
      pslverr_reg <= setup && !hit;
      if (setup && !PWRITE) begin
        prdata_reg <= rd_data;
      end
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ctrl_en_reg  <= CTRL_EN_RESET;
      irq_stat_reg <= IRQ_RESET;
      irq_mask_reg <= IRQ_RESET;
      irq_reg      <= 1'b0;
    end else begin
      if (wr && sel_ctrl) begin
        ctrl_en_reg <= PWDATA[CTRL_EN_BIT];
      end
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      irq_reg      <= |(irq_stat_next & irq_mask_next);
    end
  end

  // ==========================================================================
  // mode, line settings, gap timer
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      mode_reg    <= MODE_RUN;
      prog_reg    <= 1'b0;
      scan_en_reg <= 1'b1;
      gap_cnt_reg <= '0;
      pend_reg    <= LINE_DEFAULT;
      act_reg     <= LINE_DEFAULT;
    end else begin
      mode_reg    <= mode_next;
      prog_reg    <= (mode_next == MODE_PROG);
      scan_en_reg <= (mode_next == MODE_RUN);
      gap_cnt_reg <= gap_cnt_next;
      pend_reg    <= pend_next;
      if (ev_exit) begin
        act_reg <= pend_reg;
      end
    end
  end

  // ==========================================================================
  // answers and strobes
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      tx_valid_reg  <= 1'b0;
      tx_data_reg   <= 8'h00;
      beep_stb_reg  <= 1'b0;
      beep_cnt_reg  <= 2'h0;
      dflt_stb_reg  <= 1'b0;
      cmd_valid_reg <= 1'b0;
      cmd_line_reg  <= 1'b0;
      cmd_data_reg  <= '0;
      last_cmd_reg  <= '0;
    end else begin
      // a new answer replaces one the uart has not yet taken
      if (tx_load) begin
        tx_valid_reg <= 1'b1;
        tx_data_reg  <= tx_code;
      end else if (TX_READY) begin
        tx_valid_reg <= 1'b0;
      end
      beep_stb_reg  <= ev_exit;
      if (ev_exit) begin
        beep_cnt_reg <= EXIT_BEEPS;
      end
      dflt_stb_reg  <= ev_dflt;
      cmd_valid_reg <= ev_cmd;
      cmd_line_reg  <= ev_line;
      if (ev_cmd) begin
        cmd_data_reg <= fr_cmd;
      end
      if (fd) begin
        last_cmd_reg <= fr_cmd;
      end
    end
  end

  // ==========================================================================
  // outputs
  assign PRDATA       = prdata_reg;
  assign PREADY       = pready_reg;
  assign PSLVERR      = pslverr_reg;
  assign TX_VALID     = tx_valid_reg;
  assign TX_DATA      = tx_data_reg;
  assign PROG_MODE    = prog_reg;
  assign MOTOR_EN     = scan_en_reg;
  assign LASER_EN     = scan_en_reg;
  assign DECODE_EN    = scan_en_reg;
  assign BEEP_STB     = beep_stb_reg;
  assign BEEP_COUNT   = beep_cnt_reg;
  assign DEFAULTS_STB = dflt_stb_reg;
  assign CMD_VALID    = cmd_valid_reg;
  assign CMD_LINE     = cmd_line_reg;
  assign CMD_DATA     = cmd_data_reg;
  assign LINE_CFG     = act_reg;
  assign IRQ          = irq_reg;

  // ==========================================================================
  // checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  sequence s_answer(logic [7:0] code);
    ##1 (TX_VALID && TX_DATA == code);
  endsequence
  sequence s_left;
    ##1 (!PROG_MODE && MOTOR_EN);
  endsequence

  AST_ENTER_ACK: assert property (ev_enter |-> s_answer(CH_ACK) ##0 PROG_MODE)
    else $error("entry not acked");
  AST_CMD_ACK: assert property (ev_cmd |-> s_answer(CH_ACK) ##0 (CMD_VALID && PROG_MODE))
    else $error("command not acked");
  AST_BAD_NAK: assert property (ev_bad |-> s_answer(CH_NAK) and s_left)
    else $error("bad frame not nakked");
  AST_ABANDON: assert property (ev_abort |=> (pend_reg == act_reg) && !PROG_MODE)
    else $error("session not abandoned");
  AST_SCAN_OFF: assert property (PROG_MODE |-> !MOTOR_EN && !LASER_EN && !DECODE_EN)
    else $error("scanning while programming");
  AST_GAP_NAK: assert property (gap_hit |-> s_answer(CH_NAK) and s_left)
    else $error("gap timeout not nakked");
  AST_EXIT_BEEP: assert property (ev_exit |-> s_answer(CH_ACK)
      ##0 (BEEP_STB && BEEP_COUNT == EXIT_BEEPS && !PROG_MODE))
    else $error("exit without ack and beeps");
  AST_APPLY: assert property (ev_exit |=> LINE_CFG == $past(pend_reg))
    else $error("pending settings not applied");
  AST_LINE_HOLD: assert property (!ev_exit |=> $stable(LINE_CFG))
    else $error("line settings changed outside exit");
  AST_DEFAULTS: assert property (ev_dflt |-> s_answer(CH_ACK)
      ##0 (DEFAULTS_STB && pend_reg == LINE_DEFAULT))
    else $error("defaults not restored");
  AST_PARAM_ACK: assert property (in_prog && fd && good && fr_cmd.count == PARAM_COUNT
      |-> s_answer(CH_ACK))
    else $error("parameter digit not acked");
  AST_IGNORE: assert property (!in_prog && fd && !is_prog |-> !tx_load ##1 !PROG_MODE)
    else $error("frame answered outside programming");

endmodule

// >>> design/scci_pkg.sv
/*
  constants, types and register map of the serial configuration
  command interpreter.
  assumes a 250 MHz system clock and a byte-wide serial receiver/transmitter.
*/
package scci_pkg;

  // ==========================================================================
  // frame characters
  localparam logic [7:0] CH_STX  = 8'h02;
  localparam logic [7:0] CH_ETX  = 8'h03;
  localparam logic [7:0] CH_ACK  = 8'h06;
  localparam logic [7:0] CH_NAK  = 8'h15;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_NINE = 8'h39;

  // ==========================================================================
  // commands
  localparam int         MAX_DIGITS    = 6;
  localparam logic [2:0] FULL_COUNT    = 3'h6;
  localparam logic [2:0] PARAM_COUNT   = 3'h1;
  localparam logic [23:0] CODE_PROG     = 24'h999999;
  localparam logic [23:0] CODE_DEFAULTS = 24'h999998;
  localparam logic [3:0] LINE_CMD_LEAD = 4'h4;
  localparam logic [1:0] EXIT_BEEPS    = 2'h3;

  // ==========================================================================
  // timing
  localparam longint unsigned GAP_TIME_S  = 20;
  localparam longint unsigned CLK_FREQ_HZ = 250_000_000;
  localparam longint unsigned GAP_CYCLES  = GAP_TIME_S * CLK_FREQ_HZ;

  // ==========================================================================
  // types
  typedef enum logic [2:0] {PAR_NONE, PAR_ODD, PAR_EVEN, PAR_MARK, PAR_SPACE} scci_parity_t;
  typedef enum logic {MODE_RUN, MODE_PROG} scci_mode_t;

  typedef struct packed {
    logic [17:0]  baud;
    scci_parity_t parity;
    logic [1:0]   stop_bits;
    logic [3:0]   data_bits;
  } scci_line_t;

  typedef struct packed {
    logic [3:0]  lead;
    logic [23:0] digits;
    logic [2:0]  count;
  } scci_cmd_t;

  localparam scci_line_t LINE_DEFAULT = '{baud: 18'h02580, parity: PAR_SPACE,
                                          stop_bits: 2'h2, data_bits: 4'h7};

  // ==========================================================================
  // register map
  localparam int         APB_AW     = 8;
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_STAT  = 8'h04;
  localparam logic [7:0] ADDR_IRQS  = 8'h08;
  localparam logic [7:0] ADDR_IRQM  = 8'h0C;
  localparam logic [7:0] ADDR_PEND  = 8'h10;
  localparam logic [7:0] ADDR_ACT   = 8'h14;
  localparam logic [7:0] ADDR_LAST  = 8'h18;

  localparam int   CTRL_EN_BIT   = 0;
  localparam logic CTRL_EN_RESET = 1'b1;
  localparam int   ST_PROG_BIT   = 0;
  localparam int   ST_PEND_BIT   = 1;
  localparam int   ST_TXBUSY_BIT = 2;

  localparam int IRQ_ENTER   = 0;
  localparam int IRQ_EXIT    = 1;
  localparam int IRQ_NAK     = 2;
  localparam int IRQ_TIMEOUT = 3;
  localparam int IRQ_DEFAULT = 4;
  localparam int IRQ_LINECMD = 5;
  localparam int IRQ_W       = 6;
  localparam logic [5:0] IRQ_RESET = 6'h00;

endpackage

// >>> design/scci_framer.sv
/*
  byte-stream framer: collects the ascii digits between start and end of text.
  assumes one received byte per rx_valid pulse, synchronous to clk.
*/
`timescale 1ns/1ns
module scci_framer (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          rx_valid,
  input  wire logic [7:0]    rx_data,
  output scci_pkg::scci_cmd_t cmd,
  output logic               done,
  output logic               bad
);
  import scci_pkg::*;

  // ==========================================================================
  // decode
  function automatic logic is_digit(input logic [7:0] b);
    is_digit = (b >= CH_ZERO) && (b <= CH_NINE);
  endfunction

  logic      in_frame_reg;
  logic      done_reg;
  logic      bad_reg;
  scci_cmd_t cmd_reg;
  wire       is_stx = rx_valid && (rx_data == CH_STX);
  wire       is_etx = rx_valid && (rx_data == CH_ETX);
  wire       is_dig = rx_valid && is_digit(rx_data);
  wire [3:0] nib    = 4'(rx_data - CH_ZERO);
  wire       room   = cmd_reg.count < FULL_COUNT;

  // ==========================================================================
  // frame capture
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      in_frame_reg <= 1'b0;
      done_reg     <= 1'b0;
      bad_reg      <= 1'b0;
      cmd_reg      <= '0;
    end else begin
      done_reg <= 1'b0;
      if (is_stx) begin
        // a fresh start of text restarts a half-received frame
        in_frame_reg <= 1'b1;
        bad_reg      <= 1'b0;
        cmd_reg      <= '0;
      end else if (in_frame_reg && is_etx) begin
        in_frame_reg <= 1'b0;
        done_reg     <= 1'b1;
      end else if (in_frame_reg && is_dig && room) begin
        cmd_reg.digits <= {cmd_reg.digits[19:0], nib};
        cmd_reg.count  <= cmd_reg.count + 3'h1;
        if (cmd_reg.count == 3'h0) begin
          cmd_reg.lead <= nib;
        end
      end else if (in_frame_reg && rx_valid) begin
        bad_reg <= 1'b1;
      end
    end
  end

  assign cmd  = cmd_reg;
  assign done = done_reg;
  assign bad  = bad_reg;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_FRAME_END: assert property (done |-> $past(in_frame_reg && is_etx))
    else $error("frame completed without end of text");
  AST_DIGIT_SHIFT: assert property (in_frame_reg && is_dig && room && !is_stx
      |=> cmd_reg.count == $past(cmd_reg.count) + 3'h1
          && cmd_reg.digits[3:0] == $past(nib))
    else $error("digit not shifted in");
  AST_BAD_CHAR: assert property (in_frame_reg && rx_valid && !is_stx && !is_etx
      && !is_dig |=> bad_reg)
    else $error("non-digit not flagged");

endmodule

// >>> testbench/scci_host_model.sv
/*
  host model of the serial side: sends framed digit strings, takes answers.
  assumes its tasks are called just after a rising clock edge.
*/
`timescale 1ns/1ns
module scci_host_model (
  input  wire logic       clk,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready
);
  import scci_pkg::*;
  // ==========================================================================
  // idle line
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'hA5;
    tx_ready = 1'b0;
  end
  // ==========================================================================
  // byte stream
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      rx_valid <= 1'b1;
      rx_data  <= s[i];
      @(posedge clk);
    end
    rx_valid <= 1'b0;
    rx_data  <= ~rx_data;  // idle data flips, never a stale byte
    @(posedge clk);
  endtask
  task automatic frame(input string s);
    send($sformatf("%c%s%c", CH_STX, s, CH_ETX));
  endtask
  // ==========================================================================
  // answer, stall models a slow host
  task automatic answer(input int stall, output logic [7:0] b);
    int n;
    n = 0;
    b = 8'hXX;
    while (tx_valid !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (tx_valid === 1'b1) begin
      repeat (stall) @(posedge clk);
      tx_ready <= 1'b1;
      @(posedge clk);
      b = tx_data;
      tx_ready <= 1'b0;
      @(posedge clk);
    end
  endtask
endmodule

// >>> testbench/tb_top.sv
/*
  self-checking bench of the command interpreter: apb master and host model.
  assumes a short gap timer parameter so timeouts fit the run.
*/
`timescale 1ns/1ns
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin error_cnt++; \
  $display("unexpected at %0t: got %0h exp %0h", $time, a, e); end end
module tb_top;
  import scci_pkg::*;
  localparam scci_line_t NEW_LINE = '{18'h04B00, PAR_NONE, 2'h1, 4'h8};
  logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, irq;
  logic rx_valid, tx_valid, tx_ready, prog, mot, las, dec, beep, defs, cv, cl;
  logic [7:0] paddr, rx_data, tx_data;
  logic [31:0] pwdata, prdata, r;
  logic [1:0] beep_cnt;
  scci_cmd_t cmd_data;
  scci_line_t line_cfg;
  int error_cnt, checks_done, n_def, n_beep, n_cmd, n_line;
  logic err;
  logic [7:0] ans;
  scci_top #(.GAP_CYCLES(200)) dut (.SYS_CLK(sys_clk), .RST(rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .RX_VALID(rx_valid), .RX_DATA(rx_data),
    .TX_VALID(tx_valid), .TX_DATA(tx_data), .TX_READY(tx_ready), .PROG_MODE(prog),
    .MOTOR_EN(mot), .LASER_EN(las), .DECODE_EN(dec), .BEEP_STB(beep),
    .BEEP_COUNT(beep_cnt), .DEFAULTS_STB(defs), .CMD_VALID(cv), .CMD_LINE(cl),
    .CMD_DATA(cmd_data), .LINE_CFG(line_cfg), .IRQ(irq));
  scci_host_model host (.clk(sys_clk), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
  // ==========================================================================
  // clock and strobe counters
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    n_def  += (defs === 1'b1);
    n_beep += (beep === 1'b1);
    n_cmd  += (cv === 1'b1);
    n_line += (cl === 1'b1);
  end
  // ==========================================================================
  // apb master, one idle cycle after each transfer
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // request holds until pready is seen high; only the watchdog ends a hang
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    r   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic cmd(input string s, input logic [7:0] exp, input int stall);
    logic [7:0] b;
    host.frame(s);
    host.answer(stall, b);
    `CHK(b, exp)
  endtask
  task automatic quiet();
    repeat (12) @(posedge sys_clk);
    `CHK(tx_valid, 1'b0)
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    end_of_test();
  end
  // ==========================================================================
  // tests
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    rst = 1'b1;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    `CHK(line_cfg, LINE_DEFAULT)
    apb(1'b0, ADDR_ACT, 32'h0);
    `CHK(r[26:0], LINE_DEFAULT)
    apb(1'b1, 8'h40, 32'h1);
    `CHK(err, 1'b1)
    host.send("\x39\x02\x3A");
    host.frame("100104");
    quiet();
    cmd("999999", CH_ACK, 0);
    `CHK({prog, mot, las, dec}, 4'h8)
    cmd("999998", CH_ACK, 5);
    `CHK(n_def, 1)
    apb(1'b1, ADDR_PEND, {5'h0, NEW_LINE});
    apb(1'b0, ADDR_STAT, 32'h0);
    `CHK(r[ST_PEND_BIT], 1'b1)
    cmd("415870", CH_ACK, 0);
    `CHK(cmd_data, {4'h4, 24'h415870, 3'h6})
    cmd("0", CH_ACK, 1);
    cmd("7", CH_ACK, 1);
    cmd("1", CH_ACK, 1);
    `CHK(n_cmd, 4)
    `CHK(n_line, 1)
    `CHK(line_cfg, LINE_DEFAULT)
    cmd("999999", CH_ACK, 0);
    `CHK({prog, mot, beep_cnt, n_beep}, {2'h1, 2'h3, 32'h1})
    `CHK(line_cfg, NEW_LINE)
    cmd("999999", CH_ACK, 0);
    cmd("99999:", CH_NAK, 0);
    `CHK(prog, 1'b0)
    host.frame("99999:");
    host.frame("999998");
    quiet();
    `CHK(n_def, 1)
    apb(1'b0, ADDR_IRQS, 32'h0);
    `CHK(r[IRQ_NAK], 1'b1)
    `CHK(irq, 1'b0)
    apb(1'b1, ADDR_IRQM, 32'h4);
    `CHK(irq, 1'b1)
    apb(1'b1, ADDR_IRQS, 32'h4);
    `CHK(irq, 1'b0)
    cmd("999999", CH_ACK, 0);
    repeat (180) @(posedge sys_clk);
    `CHK(prog, 1'b1)
    host.answer(0, ans);
    `CHK(ans, CH_NAK)
    `CHK(prog, 1'b0)
    apb(1'b0, ADDR_IRQS, 32'h0);
    `CHK(r[IRQ_TIMEOUT], 1'b1)
    end_of_test();
  end
endmodule
